// file: design/xbar_regs.svh
`ifndef XBAR_REGS_SVH
`define XBAR_REGS_SVH
// ==========================================================================
// crossbar shape
`define NUM_UP      2
`define NUM_DN      2
`define NATIVE_DW   32
`define ADDR_W      32
`define UP_IDW      4
`define DN_IDW      5
// ==========================================================================
// address decode: one high address bit picks the downstream slot
`define DEC_BIT     31
// ==========================================================================
// arbitration: 4-bit static priority per upstream slot, slot 0 in the low nibble, all set equal
`define PRIO_W      4
`define UP_PRIO     8'h00
// connectivity map, bit m*NUM_DN+s set when upstream m may reach slot s
`define CONN_MAP    4'hf
// ==========================================================================
// outstanding limits and write-order queue
`define CNT_W       3
`define ACCEPT_LIM  3'h4
`define ISSUE_LIM   3'h4
`define WQ_DEPTH    4
`define WQ_AW       2
`endif

// file: design/xbar_pkg.sv
`include "xbar_regs.svh"

package xbar_pkg;

  // ========================================================================
  // address channel command, shared by write and read
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [7:0]         len;
    logic [2:0]         size;
    logic [1:0]         burst;
    logic               lock;
    logic [3:0]         cache;
    logic [2:0]         prot;
    logic [3:0]         qos;
  } cmd_t;

  typedef struct packed {
    logic [`UP_IDW-1:0] id;
    cmd_t               cmd;
  } up_a_t;

  typedef struct packed {
    logic [`DN_IDW-1:0] id;
    cmd_t               cmd;
  } dn_a_t;

  // ========================================================================
  // data and response beats
  typedef struct packed {
    logic [`NATIVE_DW-1:0]   data;
    logic [`NATIVE_DW/8-1:0] strb;
    logic                    last;
  } wbeat_t;

  typedef struct packed {
    logic [`UP_IDW-1:0] id;
    logic [1:0]         resp;
  } up_b_t;

  typedef struct packed {
    logic [`DN_IDW-1:0] id;
    logic [1:0]         resp;
  } dn_b_t;

  typedef struct packed {
    logic [`UP_IDW-1:0]    id;
    logic [`NATIVE_DW-1:0] data;
    logic [1:0]            resp;
    logic                  last;
  } up_r_t;

  typedef struct packed {
    logic [`DN_IDW-1:0]    id;
    logic [`NATIVE_DW-1:0] data;
    logic [1:0]            resp;
    logic                  last;
  } dn_r_t;

endpackage

// file: design/chan_if.sv
interface chan_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// file: design/chan_slice.sv
// ==========================================================================
// one-entry channel slice; both ready and valid come from flops, so a
// stream through it moves at most one beat every other cycle
module chan_slice #(parameter int W = 8)
(
  input  wire logic i_clock,
  input  wire logic i_srst,
  chan_if.consumer  up,
  chan_if.producer  dn
);
  logic         full;
  logic         open;
  logic [W-1:0] held;

  assign up.ready = open;
  assign dn.valid = full;
  assign dn.data  = held;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      full <= 1'b0;
      open <= 1'b1;
    end
    else if (up.valid && open)
    begin
      full <= 1'b1;
      open <= 1'b0;
    end
    else if (dn.ready && full)
    begin
      full <= 1'b0;
      open <= 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (up.valid && open)
      held <= up.data;
  end
endmodule // chan_slice

// file: design/axi_crossbar_interconnect.sv
`include "xbar_regs.svh"

module axi_crossbar_interconnect
  import xbar_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic                  i_shared_mode,
  input  wire logic [`NUM_UP-1:0]    i_up_awvalid,
  input  wire up_a_t [`NUM_UP-1:0]   i_up_aw,
  output logic [`NUM_UP-1:0]         o_up_awready,
  input  wire logic [`NUM_UP-1:0]    i_up_arvalid,
  input  wire up_a_t [`NUM_UP-1:0]   i_up_ar,
  output logic [`NUM_UP-1:0]         o_up_arready,
  input  wire logic [`NUM_UP-1:0]    i_up_wvalid,
  input  wire wbeat_t [`NUM_UP-1:0]  i_up_w,
  output logic [`NUM_UP-1:0]         o_up_wready,
  output logic [`NUM_UP-1:0]         o_up_bvalid,
  output up_b_t [`NUM_UP-1:0]        o_up_b,
  input  wire logic [`NUM_UP-1:0]    i_up_bready,
  output logic [`NUM_UP-1:0]         o_up_rvalid,
  output up_r_t [`NUM_UP-1:0]        o_up_r,
  input  wire logic [`NUM_UP-1:0]    i_up_rready,
  output logic [`NUM_DN-1:0]         o_dn_awvalid,
  output dn_a_t [`NUM_DN-1:0]        o_dn_aw,
  input  wire logic [`NUM_DN-1:0]    i_dn_awready,
  output logic [`NUM_DN-1:0]         o_dn_arvalid,
  output dn_a_t [`NUM_DN-1:0]        o_dn_ar,
  input  wire logic [`NUM_DN-1:0]    i_dn_arready,
  output logic [`NUM_DN-1:0]         o_dn_wvalid,
  output wbeat_t [`NUM_DN-1:0]       o_dn_w,
  input  wire logic [`NUM_DN-1:0]    i_dn_wready,
  input  wire logic [`NUM_DN-1:0]    i_dn_bvalid,
  input  wire dn_b_t [`NUM_DN-1:0]   i_dn_b,
  output logic [`NUM_DN-1:0]         o_dn_bready,
  input  wire logic [`NUM_DN-1:0]    i_dn_rvalid,
  input  wire dn_r_t [`NUM_DN-1:0]   i_dn_r,
  output logic [`NUM_DN-1:0]         o_dn_rready
);
  localparam int NM   = `NUM_UP;
  localparam int NS   = `NUM_DN;
  localparam int MB   = $clog2(NM);
  localparam int SB   = $clog2(NS);
  localparam int PW   = `PRIO_W;
  localparam int SW   = $bits(dn_a_t);
  localparam int NI   = 3*NM + 2*NS;
  localparam int NE   = 3*NS + 2*NM;
  localparam int I_AR = NM;
  localparam int I_W  = 2*NM;
  localparam int I_B  = 3*NM;
  localparam int I_R  = 3*NM + NS;
  localparam int E_AR = NS;
  localparam int E_W  = 2*NS;
  localparam int E_B  = 3*NS;
  localparam int E_R  = 3*NS + NM;
  localparam logic [PW*NM-1:0] PRIO = `UP_PRIO;
  localparam logic [NM*NS-1:0] CONN = `CONN_MAP;

  logic [NI-1:0]                        in_pv, in_pr, in_cv, in_cr;
  logic [NI-1:0][SW-1:0]                in_pd, in_cd;
  logic [NE-1:0]                        eg_cv, eg_cr, eg_pv, eg_pr;
  logic [NE-1:0][SW-1:0]                eg_cd, eg_pd;
  up_a_t  [NM-1:0]                      aw_hd, ar_hd;
  wbeat_t [NM-1:0]                      w_hd;
  dn_b_t  [NS-1:0]                      b_hd;
  dn_r_t  [NS-1:0]                      r_hd;
  logic                                 shared_s1, shared;
  logic [NM-1:0][`CNT_W-1:0]            wr_out, rd_out;
  logic [NS-1:0][`CNT_W-1:0]            dn_wr_out, dn_rd_out;
  logic [NM-1:0][SB-1:0]                wr_dst, rd_dst;
  logic [MB-1:0]                        aw_rr, ar_rr, aw_win, ar_win;
  logic [SB-1:0]                        aw_dst, ar_dst;
  logic [NS-1:0][`WQ_DEPTH-1:0][MB-1:0] wq;
  logic [NS-1:0][`WQ_AW-1:0]            wq_wr, wq_rd;
  logic [NS-1:0][`WQ_AW:0]              wq_cnt;
  logic [NM-1:0]                        aw_el, ar_el, aw_take, ar_take;
  logic [MB:0]                          aw_pick, ar_pick;
  logic                                 aw_gv, ar_gv, all_idle;
  dn_a_t                                aw_out, ar_out;
  logic [3:0]                           aw_qos;
  logic [NS-1:0]                        daw_push, dar_push, dw_push;
  logic [NS-1:0]                        b_take, r_take, r_fin;
  logic [NM-1:0]                        w_take, b_push, r_push, r_done;
  wbeat_t [NS-1:0]                      dw_out;
  up_b_t  [NM-1:0]                      b_out;
  up_r_t  [NM-1:0]                      r_out;

  // ========================================================================
  // channel slices: every port-facing valid and ready is a flop; there are
  // no low-power handshake ports at all
  for (genvar k = 0; k < NI; k++)
  begin : g_in
    chan_if #(.W(SW)) pin ();
    chan_if #(.W(SW)) core ();
    assign pin.valid  = in_pv[k];
    assign pin.data   = in_pd[k];
    assign in_pr[k]   = pin.ready;
    assign in_cv[k]   = core.valid;
    assign in_cd[k]   = core.data;
    assign core.ready = in_cr[k];
    chan_slice #(.W(SW)) u_slice
    (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .up      (pin),
      .dn      (core)
    );
  end

  for (genvar k = 0; k < NE; k++)
  begin : g_eg
    chan_if #(.W(SW)) core ();
    chan_if #(.W(SW)) pin ();
    assign core.valid = eg_cv[k];
    assign core.data  = eg_cd[k];
    assign eg_cr[k]   = core.ready;
    assign eg_pv[k]   = pin.valid;
    assign eg_pd[k]   = pin.data;
    assign pin.ready  = eg_pr[k];
    chan_slice #(.W(SW)) u_slice
    (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .up      (core),
      .dn      (pin)
    );
  end

  assign in_pv = {i_dn_rvalid, i_dn_bvalid, i_up_wvalid, i_up_arvalid,
                  i_up_awvalid};
  assign {o_dn_rready, o_dn_bready, o_up_wready, o_up_arready,
          o_up_awready} = in_pr;
  assign eg_pr = {i_up_rready, i_up_bready, i_dn_wready, i_dn_arready,
                  i_dn_awready};
  assign {o_up_rvalid, o_up_bvalid, o_dn_wvalid, o_dn_arvalid,
          o_dn_awvalid} = eg_pv;
  assign in_cr = {r_take, b_take, w_take, ar_take, aw_take};
  assign eg_cv = {r_push, b_push, dw_push, dar_push, daw_push};

  for (genvar m = 0; m < NM; m++)
  begin : g_up
    assign in_pd[m]       = SW'(i_up_aw[m]);
    assign in_pd[I_AR+m]  = SW'(i_up_ar[m]);
    assign in_pd[I_W+m]   = SW'(i_up_w[m]);
    assign aw_hd[m]       = in_cd[m][$bits(up_a_t)-1:0];
    assign ar_hd[m]       = in_cd[I_AR+m][$bits(up_a_t)-1:0];
    assign w_hd[m]        = in_cd[I_W+m][$bits(wbeat_t)-1:0];
    assign eg_cd[E_B+m]   = SW'(b_out[m]);
    assign eg_cd[E_R+m]   = SW'(r_out[m]);
    assign o_up_b[m]      = eg_pd[E_B+m][$bits(up_b_t)-1:0];
    assign o_up_r[m]      = eg_pd[E_R+m][$bits(up_r_t)-1:0];
  end

  // every slot runs at the native width, so no adapter is built: beat
  // counts, cache bits and byte lanes pass as received
  for (genvar s = 0; s < NS; s++)
  begin : g_dn
    assign in_pd[I_B+s]   = SW'(i_dn_b[s]);
    assign in_pd[I_R+s]   = SW'(i_dn_r[s]);
    assign b_hd[s]        = in_cd[I_B+s][$bits(dn_b_t)-1:0];
    assign r_hd[s]        = in_cd[I_R+s][$bits(dn_r_t)-1:0];
    assign eg_cd[s]       = SW'(aw_out);
    assign eg_cd[E_AR+s]  = SW'(ar_out);
    assign eg_cd[E_W+s]   = SW'(dw_out[s]);
    assign o_dn_aw[s]     = eg_pd[s][$bits(dn_a_t)-1:0];
    assign o_dn_ar[s]     = eg_pd[E_AR+s][$bits(dn_a_t)-1:0];
    assign o_dn_w[s]      = eg_pd[E_W+s][$bits(wbeat_t)-1:0];
  end

  // ========================================================================
  // address arbitration
  // two of each side, so decode and arbitration are built; a one-to-one
  // build would be bare wiring or conversion only, and a many-to-one build
  // could drop the decode
  function automatic logic [SB-1:0] dest(input cmd_t c);
    return c.addr[`DEC_BIT -: SB];
  endfunction

  // limits, single-target-per-master deadlock guard, connectivity
  function automatic logic may_issue(input logic [`CNT_W-1:0] own,
                                     input logic [SB-1:0]     last,
                                     input logic [SB-1:0]     dst,
                                     input logic [`CNT_W-1:0] slv,
                                     input int                m);
    return own < `ACCEPT_LIM && slv < `ISSUE_LIM
           && (own == '0 || last == dst) && CONN[m*NS + int'(dst)];
  endfunction

  // search starts at the rotating pointer, so equal priorities rotate
  function automatic logic [MB:0] pick(input logic [NM-1:0] el,
                                       input logic [MB-1:0] rr);
    logic [MB-1:0] idx;
    logic [MB-1:0] best;
    logic [PW-1:0] bp;
    logic          found;
    best  = '0;
    bp    = '0;
    found = 1'b0;
    for (int k = 0; k < NM; k++)
    begin
      idx = MB'((int'(rr) + k) % NM);
      if (el[idx] && (!found || PRIO[int'(idx)*PW +: PW] > bp))
      begin
        best  = idx;
        bp    = PRIO[int'(idx)*PW +: PW];
        found = 1'b1;
      end
    end
    return {found, best};
  endfunction

  // qos never enters eligibility or the pick
  always_comb
  begin
    all_idle = (wr_out == '0) && (rd_out == '0);
    for (int m = 0; m < NM; m++)
    begin
      ar_el[m] = in_cv[I_AR+m] && eg_cr[E_AR+int'(dest(ar_hd[m].cmd))]
                 && may_issue(rd_out[m], rd_dst[m], dest(ar_hd[m].cmd),
                              dn_rd_out[dest(ar_hd[m].cmd)], m)
                 && (!shared || all_idle);
    end
    ar_pick = pick(ar_el, ar_rr);
    ar_gv   = ar_pick[MB];
    ar_win  = ar_pick[MB-1:0];
    for (int m = 0; m < NM; m++)
    begin
      aw_el[m] = in_cv[m] && eg_cr[int'(dest(aw_hd[m].cmd))]
                 && may_issue(wr_out[m], wr_dst[m], dest(aw_hd[m].cmd),
                              dn_wr_out[dest(aw_hd[m].cmd)], m)
                 && wq_cnt[dest(aw_hd[m].cmd)] < (`WQ_AW+1)'(`WQ_DEPTH)
                 && (!shared || (all_idle && !in_cv[I_AR+m] && !ar_gv));
    end
    aw_pick = pick(aw_el, aw_rr);
    aw_gv   = aw_pick[MB];
    aw_win  = aw_pick[MB-1:0];
    aw_dst  = dest(aw_hd[aw_win].cmd);
    ar_dst  = dest(ar_hd[ar_win].cmd);
    aw_take = '0;
    ar_take = '0;
    aw_take[aw_win] = aw_gv;
    ar_take[ar_win] = ar_gv;
  end

  // the winner id is widened with its slot number so answers route back;
  // the lock bit is dropped, everything else goes out unchanged
  // burst length passes as is, so no burst is split into beats
  always_comb
  begin
    aw_out          = '{id: {aw_win, aw_hd[aw_win].id},
                        cmd: aw_hd[aw_win].cmd};
    aw_out.cmd.lock = 1'b0;
    ar_out          = '{id: {ar_win, ar_hd[ar_win].id},
                        cmd: ar_hd[ar_win].cmd};
    ar_out.cmd.lock = 1'b0;
    aw_qos          = aw_hd[aw_win].cmd.qos;
    for (int s = 0; s < NS; s++)
    begin
      daw_push[s] = aw_gv && aw_dst == SB'(s);
      dar_push[s] = ar_gv && ar_dst == SB'(s);
    end
  end

  // ========================================================================
  // data and response routing
  // write beats leave in address order, whole bursts from one master at a
  // time, relying on the masters not to interleave
  always_comb
  begin
    logic [MB-1:0] hm;
    hm      = '0;
    w_take  = '0;
    dw_push = '0;
    dw_out  = '0;
    for (int s = 0; s < NS; s++)
    begin
      hm = wq[s][wq_rd[s]];
      if (wq_cnt[s] != '0 && in_cv[I_W+int'(hm)] && eg_cr[E_W+s])
      begin
        w_take[hm]  = 1'b1;
        dw_push[s]  = 1'b1;
        dw_out[s]   = w_hd[hm];
      end
    end
  end

  // answers return by the slot number held in the top id bits
  always_comb
  begin
    logic [MB-1:0] bm;
    logic [MB-1:0] rm;
    bm     = '0;
    rm     = '0;
    b_push = '0;
    b_take = '0;
    r_push = '0;
    r_take = '0;
    r_done = '0;
    r_fin  = '0;
    b_out  = '0;
    r_out  = '0;
    for (int s = 0; s < NS; s++)
    begin
      bm = b_hd[s].id[`DN_IDW-1 -: MB];
      rm = r_hd[s].id[`DN_IDW-1 -: MB];
      if (in_cv[I_B+s] && eg_cr[E_B+int'(bm)] && !b_push[bm])
      begin
        b_push[bm] = 1'b1;
        b_take[s]  = 1'b1;
        b_out[bm]  = '{id: b_hd[s].id[`UP_IDW-1:0], resp: b_hd[s].resp};
      end
      if (in_cv[I_R+s] && eg_cr[E_R+int'(rm)] && !r_push[rm])
      begin
        r_push[rm] = 1'b1;
        r_take[s]  = 1'b1;
        r_done[rm] = r_hd[s].last;
        r_fin[s]   = r_hd[s].last;
        r_out[rm]  = '{id: r_hd[s].id[`UP_IDW-1:0], data: r_hd[s].data,
                       resp: r_hd[s].resp, last: r_hd[s].last};
      end
    end
  end

  // ========================================================================
  // state; one ungated clock, every flop sees every edge, some load only on a grant or push
  // mode pin is static strap-like config but still crosses two flops
  always_ff @(posedge i_clock)
  begin
    shared_s1 <= i_shared_mode;
    shared    <= shared_s1;
  end

  // counters only fall on an answer, never on time
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wr_out    <= '0;
      rd_out    <= '0;
      dn_wr_out <= '0;
      dn_rd_out <= '0;
      wr_dst    <= '0;
      rd_dst    <= '0;
    end
    else
    begin
      for (int m = 0; m < NM; m++)
      begin
        wr_out[m] <= wr_out[m] + `CNT_W'(aw_take[m]) - `CNT_W'(b_push[m]);
        rd_out[m] <= rd_out[m] + `CNT_W'(ar_take[m]) - `CNT_W'(r_done[m]);
        if (aw_take[m])
          wr_dst[m] <= aw_dst;
        if (ar_take[m])
          rd_dst[m] <= ar_dst;
      end
      for (int s = 0; s < NS; s++)
      begin
        dn_wr_out[s] <= dn_wr_out[s] + `CNT_W'(daw_push[s])
                        - `CNT_W'(b_take[s]);
        dn_rd_out[s] <= dn_rd_out[s] + `CNT_W'(dar_push[s])
                        - `CNT_W'(r_fin[s]);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      aw_rr <= '0;
      ar_rr <= '0;
    end
    else
    begin
      if (aw_gv)
        aw_rr <= MB'((int'(aw_win) + 1) % NM);
      if (ar_gv)
        ar_rr <= MB'((int'(ar_win) + 1) % NM);
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wq_wr  <= '0;
      wq_rd  <= '0;
      wq_cnt <= '0;
    end
    else
    begin
      for (int s = 0; s < NS; s++)
      begin
        if (daw_push[s])
          wq_wr[s] <= wq_wr[s] + 1'b1;
        if (dw_push[s] && dw_out[s].last)
          wq_rd[s] <= wq_rd[s] + 1'b1;
        wq_cnt[s] <= wq_cnt[s] + (`WQ_AW+1)'(daw_push[s])
                     - (`WQ_AW+1)'(dw_push[s] && dw_out[s].last);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    for (int s = 0; s < NS; s++)
    begin
      if (daw_push[s])
        wq[s][wq_wr[s]] <= aw_win;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  sequence aw_sent_s;
    aw_gv ##1 o_dn_awvalid[$past(aw_dst)];
  endsequence

  lock_dropped_a: assert property (aw_sent_s |->
    o_dn_aw[$past(aw_dst)].cmd.lock == 1'b0)
    else $error("lock bit reached a downstream slot");
  qos_len_kept_a: assert property (aw_sent_s |->
    o_dn_aw[$past(aw_dst)].cmd.qos == $past(aw_qos)
    && o_dn_aw[$past(aw_dst)].cmd.len == $past(aw_hd[aw_win].cmd.len))
    else $error("qos or burst length altered");
  single_grant_a: assert property (
    $onehot0(aw_take) && $onehot0(ar_take))
    else $error("more than one address grant in a cycle");
  accept_limit_a: assert property (
    wr_out[0] == `ACCEPT_LIM |-> !aw_take[0] ##1 wr_out[0] <= `ACCEPT_LIM)
    else $error("grant past acceptance limit");
  shared_single_a: assert property (
    shared && !all_idle |-> aw_take == '0 && ar_take == '0)
    else $error("second outstanding transfer in shared mode");
  read_first_a: assert property (
    shared && in_cv[I_AR] |-> !aw_take[0])
    else $error("write granted over own pending read");
  awvalid_held_a: assert property (
    o_dn_awvalid[0] && !i_dn_awready[0]
    |=> o_dn_awvalid[0] && $stable(o_dn_aw[0]))
    else $error("stalled address withdrawn");
  w_after_aw_a: assert property (
    o_dn_wvalid[0] |-> dn_wr_out[0] != '0)
    else $error("write data with no address issued");
  reset_idle_a: assert property (@(posedge i_clock) disable iff (1'b0)
    i_srst |=> wr_out == '0 && rd_out == '0 && wq_cnt == '0
    && eg_pv == '0)
    else $error("state not idle after reset");
endmodule // axi_crossbar_interconnect

// file: testbench/axi_slot_model.sv
`include "xbar_regs.svh"
// =====================================================================
// downstream slot model: answers single-beat bursts, optionally slow
module axi_slot_model
  import xbar_pkg::*;
(
  input  wire logic  i_clock,
  input  wire logic  i_srst,
  input  wire logic  i_slow,
  input  wire logic  i_awvalid,
  input  wire dn_a_t i_aw,
  input  wire logic  i_wvalid,
  input  wire logic  i_wlast,
  input  wire logic  i_bready,
  input  wire logic  i_arvalid,
  input  wire dn_a_t i_ar,
  input  wire logic  i_rready,
  output logic       o_ready,
  output logic       o_bvalid,
  output dn_b_t      o_b,
  output logic       o_rvalid,
  output dn_r_t      o_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic               phase;
  logic [`DN_IDW-1:0] wid;
  // stalling every other edge keeps the crossbar under back-pressure
  assign o_ready = ~(i_slow & phase);
  always_ff @(posedge i_clock)
    phase <= ~phase & ~i_srst;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_bvalid <= 1'b0;
    else if (i_wvalid && o_ready && i_wlast)
      o_bvalid <= 1'b1;
    else if (i_bready)
      o_bvalid <= 1'b0;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_awvalid && o_ready)
      wid <= i_aw.id;
    if (i_wvalid && o_ready && i_wlast)
      o_b <= '{(i_awvalid && o_ready) ? i_aw.id : wid, 2'h0};
    else if (o_bvalid && i_bready)
      o_b <= ~o_b; // a released payload must not look like the old one
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_rvalid <= 1'b0;
    else if (i_arvalid && o_ready)
      o_rvalid <= 1'b1;
    else if (i_rready)
      o_rvalid <= 1'b0;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_arvalid && o_ready)
      o_r <= '{i_ar.id, i_ar.cmd.addr, 2'h0, 1'b1};
    else if (o_rvalid && i_rready)
      o_r <= ~o_r;
  end
endmodule // axi_slot_model

// file: testbench/axi_crossbar_interconnect_tb.sv
`include "xbar_regs.svh"
module axi_crossbar_interconnect_tb
  import xbar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0, srst = 1'b1, shm = 1'b0;
  logic [1:0]   awv = '0, arv = '0, wv = '0, slow = 2'h2;
  up_a_t [1:0]  aw = '0, ar = '0;
  wbeat_t [1:0] w = '0;
  logic [1:0]   awr, arr, wr, bv, rv, dawv, darv, dwv, dbr, drr;
  logic [1:0]   rdy, dbv, drv;
  up_b_t [1:0]  b;
  up_r_t [1:0]  r;
  dn_a_t [1:0]  daw, dar;
  wbeat_t [1:0] dw;
  dn_b_t [1:0]  db;
  dn_r_t [1:0]  dr;
  int           err_count = 0, tests_run = 0;
  initial
    forever #2 clk = ~clk;
  axi_crossbar_interconnect u_dut (.i_clock(clk), .i_srst(srst),
    .i_shared_mode(shm), .i_up_awvalid(awv), .i_up_aw(aw),
    .o_up_awready(awr), .i_up_arvalid(arv), .i_up_ar(ar),
    .o_up_arready(arr), .i_up_wvalid(wv), .i_up_w(w), .o_up_wready(wr),
    .o_up_bvalid(bv), .o_up_b(b), .i_up_bready(2'h3), .o_up_rvalid(rv),
    .o_up_r(r), .i_up_rready(2'h3), .o_dn_awvalid(dawv), .o_dn_aw(daw),
    .i_dn_awready(rdy), .o_dn_arvalid(darv), .o_dn_ar(dar),
    .i_dn_arready(rdy), .o_dn_wvalid(dwv), .o_dn_w(dw), .i_dn_wready(rdy),
    .i_dn_bvalid(dbv), .i_dn_b(db), .o_dn_bready(dbr), .i_dn_rvalid(drv),
    .i_dn_r(dr), .o_dn_rready(drr));
  for (genvar s = 0; s < 2; s++)
  begin : g_slot
    axi_slot_model u_slot (.i_clock(clk), .i_srst(srst), .i_slow(slow[s]),
      .i_awvalid(dawv[s]), .i_aw(daw[s]), .i_wvalid(dwv[s]),
      .i_wlast(dw[s].last), .i_bready(dbr[s]), .i_arvalid(darv[s]),
      .i_ar(dar[s]), .i_rready(drr[s]), .o_ready(rdy[s]),
      .o_bvalid(dbv[s]), .o_b(db[s]), .o_rvalid(drv[s]), .o_r(dr[s]));
  end
  // =====================================================================
  // shared helpers
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_hi(ref logic [1:0] v, input int i);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge clk);
      if (v[i] === 1'b1)
        return;
    end
    check("handshake", 32'h1, 32'(v[i]));
  endtask
  task automatic a_chk(dn_a_t d, int m, logic [3:0] id, logic [31:0] a,
                       logic [3:0] q);
    check("lock", 32'h0, 32'(d.cmd.lock));
    check("qos", 32'(q), 32'(d.cmd.qos));
    check("id", 32'({m[0], id}), 32'(d.id));
    check("addr", a, d.cmd.addr);
  endtask
  task automatic wr_tx(int m, logic [3:0] id, logic [31:0] a, logic [3:0] q);
    #1;
    aw[m] = '{id, '{a, 8'h00, 3'h2, 2'h1, 1'b1, 4'h3, 3'h0, q}};
    awv[m] = 1'b1;
    wait_hi(awr, m);
    #1;
    awv[m] = 1'b0;
    wait_hi(dawv, int'(a[31]));
    a_chk(daw[a[31]], m, id, a, q);
    #1;
    w[m] = '{~a, 4'hf, 1'b1}; // single beat, never interleaved
    wv[m] = 1'b1;
    wait_hi(wr, m);
    #1;
    wv[m] = 1'b0;
    wait_hi(dwv, int'(a[31]));
    check("wdata", ~a, dw[a[31]].data);
    wait_hi(bv, m);
    check("bid", 32'(id), 32'(b[m].id));
  endtask
  task automatic rd_tx(int m, logic [3:0] id, logic [31:0] a, logic [3:0] q);
    #1;
    ar[m] = '{id, '{a, 8'h00, 3'h2, 2'h1, 1'b1, 4'h3, 3'h0, q}};
    arv[m] = 1'b1;
    wait_hi(arr, m);
    #1;
    arv[m] = 1'b0;
    wait_hi(darv, int'(a[31]));
    a_chk(dar[a[31]], m, id, a, q);
    wait_hi(rv, m);
    check("rdata", a, r[m].data);
    check("rid", 32'(id), 32'(r[m].id));
  endtask
  // =====================================================================
  // scenarios
  task automatic t_cross();
    wr_tx(0, 4'h3, 32'h0000_1000, 4'ha);
    wr_tx(1, 4'hc, 32'h8000_0040, 4'h5);
    rd_tx(1, 4'h7, 32'h0000_2000, 4'hf);
    rd_tx(0, 4'h1, 32'h8000_0080, 4'h0);
  endtask
  task automatic t_reset();
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clk);
    check("awready", 32'h3, 32'(awr));
    check("dn valid", 32'h0, 32'({dawv, darv, dwv}));
  endtask
  task automatic t_shared();
    #1;
    shm = 1'b1;
    repeat (3) @(posedge clk);
    rd_tx(1, 4'h2, 32'h8000_0100, 4'h9);
    wr_tx(0, 4'h4, 32'h0000_0200, 4'h6);
    // one master offers a read and a write together: read goes first
    #1;
    ar[0] = '{4'h5, '{32'h0000_0300, 8'h00, 3'h2, 2'h1, 1'b0, 4'h3, 3'h0,
                      4'h1}};
    aw[0] = '{4'h6, '{32'h0000_0400, 8'h00, 3'h2, 2'h1, 1'b0, 4'h3, 3'h0,
                      4'h1}};
    arv[0] = 1'b1;
    awv[0] = 1'b1;
    wait_hi(arr, 0);
    check("awready", 32'h1, 32'(awr[0]));
    #1;
    arv[0] = 1'b0;
    awv[0] = 1'b0;
    wait_hi(darv, 0);
    check("aw early", 32'h0, 32'(dawv[0]));
    wait_hi(rv, 0);
    check("rdata", 32'h0000_0300, r[0].data);
    check("aw early", 32'h0, 32'(dawv[0]));
    wait_hi(dawv, 0);
    check("addr", 32'h0000_0400, daw[0].cmd.addr);
    #1;
    w[0] = '{32'h1234_5678, 4'hf, 1'b1};
    wv[0] = 1'b1;
    wait_hi(wr, 0);
    #1;
    wv[0] = 1'b0;
    wait_hi(dwv, 0);
    check("wdata", 32'h1234_5678, dw[0].data);
    wait_hi(bv, 0);
    check("bid", 32'h6, 32'(b[0].id));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    t_cross();
    t_reset();
    t_shared();
    complete_run();
  end
endmodule // axi_crossbar_interconnect_tb
